/* hdl/pia_cfg.svh */
// Offsets, field positions, reset values and fixed codes of the identifier and ability registers
`ifndef PIA_CFG_SVH
`define PIA_CFG_SVH
`define PIA_ADDR_W 5
`define PIA_OFF_ID_ONE 5'h02
`define PIA_OFF_ID_TWO 5'h03
`define PIA_OFF_LOCAL_ADV 5'h04
`define PIA_OFF_PARTNER 5'h05
`define PIA_OFF_CTRL_EVT 5'h1C
`define PIA_OFF_ACTIVE_ADV 5'h1D
// Identifier value: arbitrary neutral value, bits 24:3 of the identifier
`define PIA_ID_BITS 22'h155AA5
// Model and revision: arbitrary neutral values
`define PIA_MODEL 6'h2A
`define PIA_REVISION 4'h3
`define PIA_SELECTOR 5'h01
`define PIA_ADV_RESET 16'h1DE1
`define PIA_ADV_WMASK 16'hBDE0
`define PIA_PARTNER_RESET 16'h0000
`define PIA_PARTNER_MASK 16'hEFFF
`define PIA_BIT_NP 15
`define PIA_BIT_ACK 14
`define PIA_BIT_RF 13
`define PIA_BIT_XNP 12
`define PIA_BIT_ASYM 11
`define PIA_BIT_PAUSE 10
`define PIA_BIT_T4 9
`define PIA_BIT_FX_FD 8
`define PIA_BIT_FX_HD 7
`define PIA_BIT_T_FD 6
`define PIA_BIT_T_HD 5
`define PIA_EVT_SWRST 15
`define PIA_EVT_RESTART 9
`define PIA_EVT_PWRUP 11
`endif

/* hdl/pia_pkg.sv */
// Types shared by the identifier and ability register block
package pia_pkg;
   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } pia_req_t;
   typedef struct packed {
      logic page_valid;
      logic [15:0] page;
      logic pd_fast;
      logic pd_ten;
      logic link_down;
   } pia_neg_t;
   typedef enum logic [1:0] {PIA_IDLE, PIA_LATCH} pia_state_t;
endpackage

/* hdl/pia_regs.sv */
// Identifier, local advertisement and partner ability management registers
`timescale 1ns/1ps
`include "pia_cfg.svh"
module pia_regs
   import pia_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire pia_req_t req,
   output logic [15:0] rdata,
   input wire pia_neg_t neg,
   input wire logic [15:0] ctrl_wdata,
   input wire logic ctrl_wr,
   output logic [15:0] active_adv,
   output logic [15:0] local_adv
);

   //--------------------------------------------------
   // Storage
   //--------------------------------------------------
   logic [15:0] adv_q;
   logic [15:0] active_q;
   logic [15:0] partner_q;
   logic [15:0] rdata_q;
   logic [2:0] evt_q;
   logic apply;
   logic [15:0] adv_view;
   logic [21:0] id_bits;

   assign id_bits = `PIA_ID_BITS;

   // Writable bits kept, fixed bits forced
   assign adv_view = (adv_q & `PIA_ADV_WMASK) | {11'h000, `PIA_SELECTOR};

   //--------------------------------------------------
   // Local advertisement writes
   //--------------------------------------------------
   // Written value is stored at once
   always_ff @(posedge clk) begin
      if (rst) begin
         adv_q <= `PIA_ADV_RESET;
      end else if (req.wr && req.addr == `PIA_OFF_LOCAL_ADV) begin
         adv_q <= req.wdata & `PIA_ADV_WMASK;
      end
   end

   //--------------------------------------------------
   // Taking effect
   //--------------------------------------------------
   // Control register writes and link down that commit the advertisement
   assign apply = (ctrl_wr && (ctrl_wdata[`PIA_EVT_SWRST] || ctrl_wdata[`PIA_EVT_RESTART]))
                  || (evt_q[2] && ctrl_wr && !ctrl_wdata[`PIA_EVT_PWRUP])
                  || neg.link_down;

   // Power-down level tracked to spot the return to normal operation
   always_ff @(posedge clk) begin
      if (rst) begin
         evt_q <= 3'h0;
      end else if (ctrl_wr) begin
         evt_q <= {ctrl_wdata[`PIA_EVT_PWRUP], 2'h0};
      end
   end

   // Advertisement seen by the negotiation engine
   always_ff @(posedge clk) begin
      if (rst) begin
         active_q <= `PIA_ADV_RESET | {11'h000, `PIA_SELECTOR};
      end else if (apply) begin
         active_q <= adv_view;
      end
   end

   //--------------------------------------------------
   // Partner ability
   //--------------------------------------------------
   // Loaded from received pages, parallel detect sets speed bits
   always_ff @(posedge clk) begin
      if (rst) begin
         partner_q <= `PIA_PARTNER_RESET;
      end else if (neg.page_valid) begin
         partner_q <= neg.page & `PIA_PARTNER_MASK;
      end else if (neg.pd_fast) begin
         partner_q[`PIA_BIT_FX_HD] <= 1'b1;
      end else if (neg.pd_ten) begin
         partner_q[`PIA_BIT_T_HD] <= 1'b1;
      end
   end

   //--------------------------------------------------
   // Read port
   //--------------------------------------------------
   // Data stands the cycle after the strobe, zero otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 16'h0000;
      end else if (req.rd) begin
         case (req.addr)
            `PIA_OFF_ID_ONE: rdata_q <= id_bits[15:0];
            `PIA_OFF_ID_TWO: rdata_q <= {id_bits[21:16], `PIA_MODEL, `PIA_REVISION};
            `PIA_OFF_LOCAL_ADV: rdata_q <= adv_view;
            `PIA_OFF_PARTNER: rdata_q <= partner_q;
            `PIA_OFF_ACTIVE_ADV: rdata_q <= active_q;
            default: rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign rdata = rdata_q;
   assign active_adv = active_q;
   assign local_adv = adv_view;

   //--------------------------------------------------
   // Checks
   //--------------------------------------------------
   property p_id_one;
      @(posedge clk) disable iff (rst) req.rd && req.addr == `PIA_OFF_ID_ONE |=> rdata == id_bits[15:0];
   endproperty
   a_id_one: assert property (p_id_one) else $error("identifier one wrong");

   property p_id_two;
      @(posedge clk) disable iff (rst)
         req.rd && req.addr == `PIA_OFF_ID_TWO |=> rdata == {id_bits[21:16], `PIA_MODEL, `PIA_REVISION};
   endproperty
   a_id_two: assert property (p_id_two) else $error("identifier two wrong");

   property p_fixed;
      @(posedge clk) disable iff (rst) local_adv[14] == 1'b0 && local_adv[9] == 1'b0;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed advertisement bit set");

   property p_sel;
      @(posedge clk) disable iff (rst) local_adv[4:0] == `PIA_SELECTOR;
   endproperty
   a_sel: assert property (p_sel) else $error("selector wrong");

   sequence s_adv_write;
      req.wr && req.addr == `PIA_OFF_LOCAL_ADV;
   endsequence
   property p_adv_write;
      @(posedge clk) disable iff (rst)
         s_adv_write |=> local_adv[15:5] == (($past(req.wdata) & `PIA_ADV_WMASK) >> 5);
   endproperty
   a_adv_write: assert property (p_adv_write) else $error("advertisement write lost");

   property p_hold;
      @(posedge clk) disable iff (rst) !apply |=> $stable(active_adv);
   endproperty
   a_hold: assert property (p_hold) else $error("advertisement applied early");

   property p_commit;
      @(posedge clk) disable iff (rst) neg.link_down |=> active_adv == $past(local_adv);
   endproperty
   a_commit: assert property (p_commit) else $error("advertisement not applied");

   property p_partner;
      @(posedge clk) disable iff (rst) neg.page_valid |=> partner_q[12] == 1'b0 && partner_q[4:0] == $past(neg.page[4:0]);
   endproperty
   a_partner: assert property (p_partner) else $error("partner page wrong");

   property p_pd;
      @(posedge clk) disable iff (rst) !neg.page_valid && neg.pd_fast |=> partner_q[`PIA_BIT_FX_HD];
   endproperty
   a_pd: assert property (p_pd) else $error("parallel detect not shown");

   // Ten parallel detect sets the half duplex bit when neither a page nor a fast detect arrives
   property p_pd_ten;
      @(posedge clk) disable iff (rst)
         !neg.page_valid && !neg.pd_fast && neg.pd_ten |=> partner_q[`PIA_BIT_T_HD];
   endproperty
   a_pd_ten: assert property (p_pd_ten) else $error("ten parallel detect not shown");

   // A page carries every partner bit except bit 12, the XNP bit
   property p_partner_bits;
      @(posedge clk) disable iff (rst)
         neg.page_valid |=> partner_q[15:13] == $past(neg.page[15:13]) && partner_q[11:5] == $past(neg.page[11:5]);
   endproperty
   a_partner_bits: assert property (p_partner_bits) else $error("partner ability bits wrong");

   // Restart or software reset commits the stored advertisement
   sequence s_ctrl_commit;
      ctrl_wr && (ctrl_wdata[`PIA_EVT_SWRST] || ctrl_wdata[`PIA_EVT_RESTART]);
   endsequence
   property p_ctrl_commit;
      @(posedge clk) disable iff (rst) s_ctrl_commit |=> active_adv == $past(local_adv);
   endproperty
   a_ctrl_commit: assert property (p_ctrl_commit) else $error("control commit missed");

   property p_rd_idle;
      @(posedge clk) disable iff (rst) !req.rd |=> rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule

/* verification/pia_lp_model.sv */
// Link partner model feeding pages and detect pulses to the block
`timescale 1ns/1ps
module pia_lp_model
   import pia_pkg::*;
(
   input wire logic clk,
   input wire logic [2:0] kick,
   input wire logic [15:0] page,
   output pia_neg_t neg
);
   // One-cycle pulses; the page bus toggles while not qualified
   always_ff @(posedge clk) begin
      neg.page_valid <= kick == 3'h1;
      neg.page <= (kick == 3'h1) ? page : ~neg.page;
      neg.pd_fast <= kick == 3'h2;
      neg.pd_ten <= kick == 3'h3;
      neg.link_down <= kick == 3'h4;
   end
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the identifier and ability registers
`timescale 1ns/1ps
`include "pia_cfg.svh"
module tb_top;
   import pia_pkg::*;
   typedef struct {logic [4:0] a; logic w; logic [15:0] d; logic [15:0] e;} pia_row_t;
   localparam logic [21:0] ID = `PIA_ID_BITS;
   localparam logic [15:0] ID2 = {ID[21:16], `PIA_MODEL, `PIA_REVISION};
   logic clk = 1'b0;
   logic rst = 1'b1;
   pia_req_t req = '0;
   logic [15:0] ctrl_wdata = 16'h0000;
   logic ctrl_wr = 1'b0;
   logic [2:0] kick = 3'h0;
   logic [15:0] page = 16'h0000;
   pia_neg_t neg;
   logic [15:0] rdata, active_adv, local_adv;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   pia_row_t rows[12] = '{
      '{5'h1D, 1'b1, 16'h0000, 16'h1DE1},
      '{5'h02, 1'b0, 16'h0000, ID[15:0]},
      '{5'h03, 1'b0, 16'h0000, ID2},
      '{5'h04, 1'b0, 16'h0000, 16'h1DE1},
      '{5'h05, 1'b0, 16'h0000, 16'h0000},
      '{5'h10, 1'b0, 16'h0000, 16'h0000},
      '{5'h02, 1'b1, 16'hFFFF, ID[15:0]},
      '{5'h03, 1'b1, 16'h0000, ID2},
      '{5'h04, 1'b1, 16'hFFFF, 16'hBDE1},
      '{5'h04, 1'b1, 16'h4200, 16'h0001},
      '{5'h04, 1'b1, 16'h1C00, 16'h1C01},
      '{5'h04, 1'b1, 16'h01E0, 16'h01E1}
   };
   pia_regs pia_regs_inst (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .neg(neg),
      .ctrl_wdata(ctrl_wdata), .ctrl_wr(ctrl_wr), .active_adv(active_adv), .local_adv(local_adv));
   pia_lp_model pia_lp_model_inst (.clk(clk), .kick(kick), .page(page), .neg(neg));
   // ------------------------------------------------------------
   // Bus and check tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] v);
      @(posedge clk);
      req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask
   task automatic cw(input logic [15:0] d);
      @(posedge clk);
      ctrl_wdata <= d;
      ctrl_wr <= 1'b1;
      @(posedge clk);
      ctrl_wr <= 1'b0;
      @(negedge clk);
   endtask
   task automatic lk(input logic [2:0] k, input logic [15:0] p);
      @(posedge clk);
      kick <= k;
      page <= p;
      @(posedge clk);
      kick <= 3'h0;
      @(posedge clk);
      @(negedge clk);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Clock and hang guard
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         close_out;
      end
   end
   // Table rows, then commit events, partner loads and a second reset
   initial begin
      logic [15:0] v;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      chk("active_reset", active_adv, `PIA_ADV_RESET);
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, v);
         chk("row", v, rows[i].e);
      end
      chk("held", active_adv, `PIA_ADV_RESET);
      cw(16'h0200);
      chk("restart", active_adv, 16'h01E1);
      wr(5'h04, 16'h0000);
      cw(16'h8000);
      chk("swreset", active_adv, 16'h0001);
      wr(5'h04, 16'hFFFF);
      cw(16'h0800);
      chk("pwrdn", active_adv, 16'h0001);
      cw(16'h0000);
      chk("pwrup", active_adv, 16'hBDE1);
      wr(5'h04, 16'h2001);
      lk(3'h4, 16'h0000);
      chk("linkdown", active_adv, 16'h2001);
      lk(3'h1, 16'hFFFF);
      wr(5'h05, 16'h0000);
      rd(5'h05, v);
      chk("partner", v, `PIA_PARTNER_MASK);
      lk(3'h1, 16'h0000);
      lk(3'h3, 16'h0000);
      rd(5'h05, v);
      chk("pd_ten", v, 16'h0020);
      lk(3'h2, 16'h0000);
      rd(5'h05, v);
      chk("pd_fast", v, 16'h00A0);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("local_rst", local_adv, `PIA_ADV_RESET);
      rd(5'h05, v);
      chk("partner_rst", v, 16'h0000);
      close_out;
   end
endmodule
